// [rtl/upc_pkg.sv]
// upc_pkg: shared types, codes and timing constants of the usb port power state controller
package upc_pkg;

   // clock rate in MHz, used to turn times into cycle counts
   localparam int unsigned CLK_MHZ = 250;

   // qualification and fault timing in microseconds (plain defaults)
   localparam int unsigned ATTACH_QUALIFY_TIME_US = 100;
   localparam int unsigned REMOVAL_QUALIFY_TIME_US = 100;
   localparam int unsigned FAULT_CYCLE_TIME_US = 10000;
   localparam int unsigned FAULT_TEST_TIME_US = 100;
   // data-minus answer deadline in the charging-port handshake, in ms
   localparam int unsigned CDP_RESPONSE_TIME_MS = 20;

   // derived cycle counts (longest times rounded down, least times exact here)
   localparam int unsigned ATTACH_QUALIFY_CYC = ATTACH_QUALIFY_TIME_US * CLK_MHZ;
   localparam int unsigned REMOVAL_QUALIFY_CYC = REMOVAL_QUALIFY_TIME_US * CLK_MHZ;
   localparam int unsigned FAULT_CYCLE_CYC = FAULT_CYCLE_TIME_US * CLK_MHZ;
   localparam int unsigned FAULT_TEST_CYC = FAULT_TEST_TIME_US * CLK_MHZ;
   localparam int unsigned CDP_RESPONSE_CYC = CDP_RESPONSE_TIME_MS * 1000 * CLK_MHZ;

   // mode control codes, ordered {mode_a, mode_b, emulation_enable}
   localparam logic [2:0] CODE_DCE_0 = 3'h1;
   localparam logic [2:0] CODE_PASS_0 = 3'h2;
   localparam logic [2:0] CODE_DCP = 3'h3;
   localparam logic [2:0] CODE_SDP = 3'h4;
   localparam logic [2:0] CODE_DCE_1 = 3'h5;
   localparam logic [2:0] CODE_PASS_1 = 3'h6;
   localparam logic [2:0] CODE_CDP = 3'h7;

   // width of the synchronised control/sense vector
   localparam int unsigned SYNC_W = 23;
   localparam int unsigned CNT_W = 32;

   // fault comparator inputs
   typedef struct packed {
      logic over_current;
      logic over_voltage;
      logic under_voltage;
      logic back_voltage;
      logic discharge_err;
      logic over_temp;
   } upc_fault_t;

   // host mode selection controls
   typedef struct packed {
      logic mode_a;
      logic mode_b;
      logic emulation_enable;
   } upc_mode_ctrl_t;

   // power path and data line switch drives
   typedef struct packed {
      logic bypass_on;
      logic port_on;
      logic discharge_on;
      logic hs_switch_on;
      logic dcp_short;
      logic cc_limit;
   } upc_switch_t;

   localparam upc_switch_t SWITCH_RESET = '0;

   // power states
   typedef enum {
      ST_DETECT,
      ST_MODE_DISCH,
      ST_ACTIVE,
      ST_REM_DISCH,
      ST_ERR_WAIT,
      ST_ERR_TEST,
      ST_ERR_LATCH
   } upc_state_t;

   // decoded active modes
   typedef enum {
      MD_NONE,
      MD_DCE,
      MD_PASS,
      MD_DCP,
      MD_SDP,
      MD_CDP
   } upc_mode_t;

endpackage

// [rtl/upc_qual_filter.sv]
// upc_qual_filter: holds a level for more than a set number of cycles before qualifying it
`timescale 1ns/1ps
module upc_qual_filter
   import upc_pkg::*;
#(
   parameter int unsigned LIMIT = 100
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic level_i,
   output logic qualified_o
);

   logic [CNT_W-1:0] cnt_q; // cycles the level has held
   logic [CNT_W-1:0] cnt_d;
   logic qual_q; // level held longer than the limit
   logic qual_d;

   generate
      if (LIMIT < 1) begin : g_bad_limit
         $error("upc_qual_filter: LIMIT must be at least one cycle");
      end
   endgenerate

   // count while enabled and the level holds; any gap restarts the window
   always_comb begin
      cnt_d = cnt_q;
      qual_d = 1'b0;
      if (!enable_i || !level_i) begin
         cnt_d = '0;
      end else if (cnt_q > CNT_W'(LIMIT)) begin
         qual_d = 1'b1; // strictly longer than the limit
      end else begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   // registers only
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         qual_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         qual_q <= qual_d;
      end
   end

   assign qualified_o = qual_q;

endmodule

// [rtl/upc_port_ctrl.sv]
// upc_port_ctrl: usb port power state controller (fault, detect, active mode, cdp/dcp handshakes)
// Function
// - latched or auto fault mode, bus bit or pin
// - six fault sources, including discharge and temperature
// - auto mode: fault enters error, notify asserted
// - latched mode stays in error until commanded
// - enable fall or flag clear retests once
// - detect: no emulation, data switch open
// - bypass and port switches never both closed
// - detect uses bypass, active uses port switch
// - qualified attach load drives attach low
// - attached plus enable and supply enter active
// - detection enable qualifies removal in active/detect
// - removal opens switches, discharges, returns detect
// - three mode controls decode to active mode
// - sdp is pass-through preceded by discharge
// - switching between bc modes cycles vbus
// - pass-through: data switch closed, trip limit
// - cdp: discharge, data switch closed, constant current
// - cdp: minus follows plus mid-level, then low
// - standalone dcp: short, timeouts off, cycle off
// - dcp charging keeps short, switch open, cc
`timescale 1ns/1ps
module upc_port_ctrl
   import upc_pkg::*;
#(
   parameter int unsigned ATTACH_QUAL_CYCLES = ATTACH_QUALIFY_CYC,
   parameter int unsigned REMOVAL_QUAL_CYCLES = REMOVAL_QUALIFY_CYC,
   parameter int unsigned FAULT_CYCLE_CYCLES = FAULT_CYCLE_CYC,
   parameter int unsigned FAULT_TEST_CYCLES = FAULT_TEST_CYC
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic port_power_enable_i,
   input wire upc_mode_ctrl_t mode_ctrl_i,
   input wire logic detection_enable_i,
   input wire logic bus_active_i,
   input wire logic latch_cfg_i,
   input wire logic fault_mode_pin_i,
   input wire logic fault_flag_clear_i,
   input wire logic status_clear_i,
   input wire logic other_notify_i,
   input wire logic load_above_attach_i,
   input wire logic load_below_removal_i,
   input wire logic main_supply_ok_i,
   input wire logic vbus_discharged_i,
   input wire logic dp_mid_level_i,
   input wire logic dp_low_i,
   input wire upc_fault_t fault_i,
   output upc_switch_t switch_o,
   output logic attach_out_n_o,
   output logic attach_pin_status_o,
   output logic attach_status_o,
   output logic removal_status_o,
   output logic notify_n_o,
   output logic dm_drive_o,
   output logic dce_cycle_o,
   output logic emu_timeout_en_o
);

   generate
      if (FAULT_CYCLE_CYCLES < 1 || FAULT_TEST_CYCLES < 1) begin : g_bad_fault_time
         $error("upc_port_ctrl: fault timing must be at least one cycle");
      end
   endgenerate

   // two-flop synchroniser for every pin input; stage one feeds stage two only
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   assign raw = {fault_i, dp_low_i, dp_mid_level_i, vbus_discharged_i, main_supply_ok_i,
                 load_below_removal_i, load_above_attach_i, other_notify_i, status_clear_i,
                 fault_flag_clear_i, fault_mode_pin_i, latch_cfg_i, bus_active_i,
                 detection_enable_i, mode_ctrl_i, port_power_enable_i};

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   // synchronised views
   logic port_power_enable_s;
   logic [2:0] mode_code_s;
   logic det_en_s, bus_act_s, latch_cfg_s, latch_pin_s, flag_clr_s, stat_clr_s, other_s;
   logic attach_load_s, rem_load_s, supply_ok_s, discharged_s, dp_mid_s, dp_low_s;
   upc_fault_t fault_s;
   assign port_power_enable_s = sync2_q[0];
   assign mode_code_s = sync2_q[3:1];
   assign det_en_s = sync2_q[4];
   assign bus_act_s = sync2_q[5];
   assign latch_cfg_s = sync2_q[6];
   assign latch_pin_s = sync2_q[7];
   assign flag_clr_s = sync2_q[8];
   assign stat_clr_s = sync2_q[9];
   assign other_s = sync2_q[10];
   assign attach_load_s = sync2_q[11];
   assign rem_load_s = sync2_q[12];
   assign supply_ok_s = sync2_q[13];
   assign discharged_s = sync2_q[14];
   assign dp_mid_s = sync2_q[15];
   assign dp_low_s = sync2_q[16];
   assign fault_s = upc_fault_t'(sync2_q[22:17]);

   // state registers
   upc_state_t st_q, st_d;
   upc_mode_t mode_q, mode_d; // mode being run in active
   logic [CNT_W-1:0] cnt_q, cnt_d; // error wait / test timer
   logic attached_q, attached_d; // qualified attach outstanding
   logic pwr_prev_q; // last enable, for the falling edge
   logic clr_prev_q; // last flag clear, for the rising edge

   // qualification filters
   logic attach_qual;
   logic rem_qual;
   logic attach_en;
   logic rem_en;
   assign attach_en = (st_q == ST_DETECT) && !attached_q;
   assign rem_en = det_en_s && attached_q &&
                   (st_q == ST_DETECT || st_q == ST_ACTIVE || st_q == ST_MODE_DISCH);

   upc_qual_filter #(.LIMIT(ATTACH_QUAL_CYCLES)) u_attach_qual (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(attach_en),
      .level_i(attach_load_s),
      .qualified_o(attach_qual)
   );

   upc_qual_filter #(.LIMIT(REMOVAL_QUAL_CYCLES)) u_rem_qual (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(rem_en),
      .level_i(rem_load_s),
      .qualified_o(rem_qual)
   );

   // mode decode from {mode_a, mode_b, emulation_enable}; 000 selects no mode
   upc_mode_t sel_mode;
   always_comb begin
      case (mode_code_s)
         CODE_DCE_0, CODE_DCE_1: sel_mode = MD_DCE;
         CODE_PASS_0, CODE_PASS_1: sel_mode = MD_PASS;
         CODE_DCP: sel_mode = MD_DCP;
         CODE_SDP: sel_mode = MD_SDP;
         CODE_CDP: sel_mode = MD_CDP;
         default: sel_mode = MD_NONE;
      endcase
   end

   // helper terms
   logic fault_any, latched_mode, recover_cmd, sel_is_bc, removal_hit;
   assign fault_any = |fault_s;
   assign latched_mode = bus_act_s ? latch_cfg_s : latch_pin_s;
   assign recover_cmd = (pwr_prev_q && !port_power_enable_s) || (flag_clr_s && !clr_prev_q);
   // sdp, dcp and cdp all discharge on entry, which also cycles vbus between them
   assign sel_is_bc = (sel_mode == MD_SDP) || (sel_mode == MD_DCP) || (sel_mode == MD_CDP);
   assign removal_hit = rem_qual && rem_en;

   // power state sequencing
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      cnt_d = cnt_q;
      attached_d = attached_q;
      if (attach_qual && attach_en) begin
         attached_d = 1'b1;
      end
      case (st_q)
         ST_DETECT, ST_MODE_DISCH, ST_ACTIVE: begin
            if (fault_any) begin
               // open everything; latched mode parks until the host acts
               st_d = latched_mode ? ST_ERR_LATCH : ST_ERR_WAIT;
               cnt_d = '0;
            end else if (removal_hit) begin
               st_d = ST_REM_DISCH;
               attached_d = 1'b0;
            end else if (st_q == ST_DETECT) begin
               if (attached_q && port_power_enable_s && supply_ok_s && sel_mode != MD_NONE) begin
                  mode_d = sel_mode;
                  st_d = sel_is_bc ? ST_MODE_DISCH : ST_ACTIVE;
               end
            end else if (st_q == ST_MODE_DISCH) begin
               if (discharged_s) begin
                  st_d = ST_ACTIVE;
               end
            end else if (mode_q == MD_PASS && !port_power_enable_s) begin
               st_d = ST_ACTIVE; // pass-through persists with power disabled
            end else if (!port_power_enable_s || mode_q == MD_NONE) begin
               st_d = ST_DETECT;
            end else if (sel_mode != mode_q) begin
               mode_d = sel_mode;
               if (sel_mode == MD_NONE) begin
                  st_d = ST_DETECT;
               end else begin
                  st_d = sel_is_bc ? ST_MODE_DISCH : ST_ACTIVE;
               end
            end
         end
         ST_REM_DISCH: begin
            // return to detect whatever the enable says
            if (discharged_s) begin
               st_d = ST_DETECT;
            end
         end
         ST_ERR_WAIT: begin
            // fixed wait with no host involvement
            if (cnt_q >= CNT_W'(FAULT_CYCLE_CYCLES - 1)) begin
               st_d = ST_ERR_TEST;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         ST_ERR_TEST: begin
            // sample faults at the end of the test window
            if (cnt_q >= CNT_W'(FAULT_TEST_CYCLES - 1)) begin
               cnt_d = '0;
               if (fault_any) begin
                  st_d = ST_ERR_WAIT;
               end else begin
                  st_d = (attached_q && mode_q != MD_NONE) ? ST_ACTIVE : ST_DETECT;
               end
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         ST_ERR_LATCH: begin
            // one check per host command; a standing fault needs another command
            if (recover_cmd && !fault_any) begin
               st_d = (attached_q && mode_q != MD_NONE) ? ST_ACTIVE : ST_DETECT;
            end
         end
         default: begin
            st_d = ST_DETECT;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= ST_DETECT;
         mode_q <= MD_NONE;
         cnt_q <= '0;
         attached_q <= 1'b0;
         pwr_prev_q <= 1'b0;
         clr_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         cnt_q <= cnt_d;
         attached_q <= attached_d;
         pwr_prev_q <= port_power_enable_s;
         clr_prev_q <= flag_clr_s;
      end
   end

   // output path, computed from the next state so every output is a flop
   upc_switch_t sw_q, sw_d;
   logic attach_n_q, attach_n_d, att_stat_q, att_stat_d, rem_stat_q, rem_stat_d;
   logic notify_n_q, notify_n_d, dm_q, dm_d, dce_q, dce_d, emu_to_q, emu_to_d;
   logic err_next;
   assign err_next = (st_d == ST_ERR_WAIT) || (st_d == ST_ERR_TEST) || (st_d == ST_ERR_LATCH);

   always_comb begin
      sw_d = SWITCH_RESET; // error and default: all switches open
      dce_d = 1'b0;
      emu_to_d = 1'b0;
      dm_d = 1'b0;
      case (st_d)
         ST_DETECT: sw_d.bypass_on = 1'b1; // aux supply, capped current, data open
         ST_MODE_DISCH, ST_REM_DISCH: sw_d.discharge_on = 1'b1;
         ST_ACTIVE: begin
            sw_d.port_on = 1'b1; // main supply path, bypass stays open
            case (mode_d)
               MD_PASS, MD_SDP: sw_d.hs_switch_on = 1'b1; // trip limiting
               MD_CDP: begin
                  sw_d.hs_switch_on = 1'b1;
                  sw_d.cc_limit = 1'b1;
                  // follow the plus line, hold between levels
                  if (dp_mid_s) begin
                     dm_d = 1'b1;
                  end else if (dp_low_s) begin
                     dm_d = 1'b0;
                  end else begin
                     dm_d = dm_q;
                  end
               end
               MD_DCP: begin
                  sw_d.dcp_short = 1'b1; // timeouts stay off standalone
                  sw_d.cc_limit = 1'b1;
               end
               MD_DCE: begin
                  sw_d.cc_limit = 1'b1;
                  dce_d = 1'b1;
                  emu_to_d = 1'b1; // timeout and draw check on in cycling
               end
               default: sw_d.port_on = 1'b1;
            endcase
         end
         default: sw_d = SWITCH_RESET;
      endcase
   end

   // status bits: a new event beats a same-cycle clear
   always_comb begin
      attach_n_d = !attached_d;
      att_stat_d = (attach_qual && attach_en) ? 1'b1 : (stat_clr_s ? 1'b0 : att_stat_q);
      rem_stat_d = (st_d == ST_REM_DISCH && st_q != ST_REM_DISCH) ? 1'b1 :
                   (stat_clr_s ? 1'b0 : rem_stat_q);
      notify_n_d = !(err_next || other_s);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sw_q <= SWITCH_RESET;
         attach_n_q <= 1'b1;
         att_stat_q <= 1'b0;
         rem_stat_q <= 1'b0;
         notify_n_q <= 1'b1;
         dm_q <= 1'b0;
         dce_q <= 1'b0;
         emu_to_q <= 1'b0;
      end else begin
         sw_q <= sw_d;
         attach_n_q <= attach_n_d;
         att_stat_q <= att_stat_d;
         rem_stat_q <= rem_stat_d;
         notify_n_q <= notify_n_d;
         dm_q <= dm_d;
         dce_q <= dce_d;
         emu_to_q <= emu_to_d;
      end
   end

   assign switch_o = sw_q;
   assign attach_out_n_o = attach_n_q;
   assign attach_pin_status_o = attached_q;
   assign attach_status_o = att_stat_q;
   assign removal_status_o = rem_stat_q;
   assign notify_n_o = notify_n_q;
   assign dm_drive_o = dm_q;
   assign dce_cycle_o = dce_q;
   assign emu_timeout_en_o = emu_to_q;

   // checks
   a_switch_exclusive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !(switch_o.bypass_on && switch_o.port_on)) else $error("bypass and port switch both closed");
   a_fault_enters_err: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ACTIVE && fault_any && !latched_mode) |=> (st_q == ST_ERR_WAIT && !notify_n_o
      && !switch_o.port_on)) else $error("fault did not enter error with notify");
   a_latch_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ERR_LATCH && !recover_cmd) |=> st_q == ST_ERR_LATCH) else $error("latched error left");
   a_auto_wait_len: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ERR_WAIT && $past(st_q) != ST_ERR_WAIT) |-> cnt_q == '0) else $error("wait timer not cleared");
   a_attach_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (attach_qual && attach_en && !fault_any) |=> (!attach_out_n_o && attach_status_o
      && attach_pin_status_o)) else $error("attach not reported");
   a_removal_open: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_REM_DISCH) |-> (!switch_o.port_on && !switch_o.bypass_on && switch_o.discharge_on
      && attach_out_n_o && (removal_status_o || $past(st_q) == ST_REM_DISCH)))
      else $error("removal outputs wrong");
   a_cdp_answer: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ACTIVE && mode_q == MD_CDP && st_d == ST_ACTIVE && mode_d == MD_CDP && dp_mid_s)
      |=> dm_drive_o) else $error("minus line not driven");
   a_pass_path: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ACTIVE && mode_q == MD_PASS) |-> (switch_o.hs_switch_on && !switch_o.cc_limit
      && !switch_o.discharge_on)) else $error("pass-through path wrong");
   a_dcp_path: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ACTIVE && mode_q == MD_DCP) |-> (switch_o.dcp_short && !switch_o.hs_switch_on
      && switch_o.cc_limit && !emu_timeout_en_o)) else $error("dcp path wrong");
   a_bc_cycles_vbus: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q == ST_ACTIVE && port_power_enable_s && !fault_any && !removal_hit && sel_is_bc && sel_mode != mode_q)
      |=> (st_q == ST_MODE_DISCH && switch_o.discharge_on)) else $error("bc switch without discharge");
   a_notify_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      notify_n_o == !((st_q == ST_ERR_WAIT || st_q == ST_ERR_TEST || st_q == ST_ERR_LATCH)
      || $past(other_s))) else $error("notify does not track sources");

endmodule

// [sim/upc_dev_model.sv]
// upc_dev_model: portable device on the port, loads vbus and probes the plus line
`timescale 1ns/1ps
module upc_dev_model
   import upc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic plugged_i, // device present on the port
   input wire logic probe_i, // device puts mid level on the plus line
   input wire upc_switch_t switch_i,
   output logic load_above_o = 1'b0,
   output logic load_below_o = 1'b1,
   output logic discharged_o = 1'b0,
   output logic dp_mid_o = 1'b0,
   output logic dp_low_o = 1'b1
);
   int dis_cnt = 0; // cycles of discharge seen so far
   logic fed; // vbus reaches the device through either switch
   assign fed = switch_i.bypass_on || switch_i.port_on;
   // outputs move on the falling edge, clear of the sampling edge
   always @(negedge sys_clk_i) begin
      load_above_o <= plugged_i && fed; // no supply means no load at all
      load_below_o <= !(plugged_i && fed);
      dis_cnt <= switch_i.discharge_on ? dis_cnt + 1 : 0;
      discharged_o <= dis_cnt >= 3; // vbus needs a few cycles to fall
      dp_mid_o <= plugged_i && probe_i; // an unplugged device leaves the line low
      dp_low_o <= !(plugged_i && probe_i);
   end
endmodule

// [sim/upc_port_ctrl_tb.sv]
// upc_port_ctrl_tb: self-checking bench of the port power state controller
`timescale 1ns/1ps
module upc_port_ctrl_tb;
   import upc_pkg::*;
   logic clk = 1'b0; // 250 MHz system clock
   logic rst = 1'b1; // asynchronous reset, high
   logic en = 1'b0, det_en = 1'b0, bus = 1'b0, cfg = 1'b0, pin = 1'b0, fclr = 1'b0;
   logic sclr = 1'b0, oth = 1'b0, sup = 1'b1, plug = 1'b0, probe = 1'b0;
   upc_mode_ctrl_t mode = '0; // code 000 keeps the port in detect
   upc_fault_t fault = '0;
   upc_switch_t sw;
   logic att_n, att_pin, att_st, rem_st, ntf_n, dm, dce, emu, ld_hi, ld_lo, dis, dpm, dpl;
   logic [7:0] mon; // watched outputs packed for the wait task
   int failures = 0;
   int comparisons = 0;
   assign mon = {att_pin, sw.discharge_on, dm, rem_st, att_n, ntf_n, sw.bypass_on, sw.port_on};
   // short counts keep the fault cycle and qualification quick
   upc_port_ctrl #(.ATTACH_QUAL_CYCLES(4), .REMOVAL_QUAL_CYCLES(4), .FAULT_CYCLE_CYCLES(20),
      .FAULT_TEST_CYCLES(4)) u_upc_port_ctrl (.sys_clk_i(clk), .sys_rst_i(rst),
      .port_power_enable_i(en), .mode_ctrl_i(mode), .detection_enable_i(det_en), .bus_active_i(bus),
      .latch_cfg_i(cfg), .fault_mode_pin_i(pin), .fault_flag_clear_i(fclr), .status_clear_i(sclr),
      .other_notify_i(oth), .load_above_attach_i(ld_hi), .load_below_removal_i(ld_lo),
      .main_supply_ok_i(sup), .vbus_discharged_i(dis), .dp_mid_level_i(dpm), .dp_low_i(dpl),
      .fault_i(fault), .switch_o(sw), .attach_out_n_o(att_n), .attach_pin_status_o(att_pin),
      .attach_status_o(att_st), .removal_status_o(rem_st), .notify_n_o(ntf_n), .dm_drive_o(dm),
      .dce_cycle_o(dce), .emu_timeout_en_o(emu));
   upc_dev_model u_upc_dev_model (.sys_clk_i(clk), .plugged_i(plug), .probe_i(probe), .switch_i(sw),
      .load_above_o(ld_hi), .load_below_o(ld_lo), .discharged_o(dis), .dp_mid_o(dpm), .dp_low_o(dpl));
   initial begin
      forever #2 clk = ~clk;
   end
   // expected {dce, discharge seen, timeout, data switch, short, cc} per mode code
   function automatic logic [5:0] model(int c);
      case (c)
         1, 5: return 6'h29; // cycling: timeout on, data switch open, cc
         2, 6: return 6'h04;
         3: return 6'h13;
         4: return 6'h14;
         default: return 6'h15;
      endcase
   endfunction
   task automatic give_verdict();
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // bounded wait for one watched output; running out counts and ends the run
   task automatic wt(int b, logic v, int n);
      for (int i = 0; i < n && mon[b] !== v; i++) @(negedge clk);
      chk("wait", {7'h0, v}, {7'h0, mon[b]});
      if (mon[b] !== v) give_verdict();
   endtask
   initial begin
      int c, k;
      logic d;
      logic [5:0] got; // observed {dce, discharge seen, timeout, data switch, short, cc}
      void'($urandom(32'h89A0));
      // the initial value of rst raises no edge, so flops clear only at the first clock
      repeat (2) @(negedge clk);
      chk("reset", 8'h0C, mon);
      rst = 1'b0;
      plug = 1'b1;
      wt(3, 1'b0, 40);
      chk("detect", 8'h86, mon);
      chk("attach", 8'h01, {6'h0, sw.hs_switch_on, att_st});
      en = 1'b1;
      // walk every code from 1 to 7; pass-through is left with the enable high
      for (c = 1; c < 8; c++) begin
         mode = upc_mode_ctrl_t'(c[2:0]);
         d = 1'b0;
         for (k = 0; k < 200 && !(k > 10 && sw.port_on === 1'b1); k++) begin
            @(negedge clk);
            d |= sw.discharge_on;
         end
         got = {dce, d, emu, sw.hs_switch_on, sw.dcp_short, sw.cc_limit};
         chk("mode", {2'h0, model(c)}, {2'h0, got});
         chk("path", 8'h01, {6'h0, mon[1:0]});
      end
      probe = 1'b1;
      wt(5, 1'b1, 10);
      probe = 1'b0;
      wt(5, 1'b0, 10);
      // auto recovery, with a second notification source held over it
      fault = upc_fault_t'(6'h01 << ($urandom % 6));
      wt(2, 1'b0, 10);
      chk("off", 8'h00, {6'h0, mon[1:0]});
      oth = 1'b1;
      fault = '0;
      wt(0, 1'b1, 100);
      chk("hold", 8'h00, {7'h0, ntf_n});
      oth = 1'b0;
      wt(2, 1'b1, 10);
      // latched: pin selects first, then the bus bit
      for (k = 0; k < 2; k++) begin
         bus = k[0];
         cfg = k[0];
         pin = !k[0];
         fault = upc_fault_t'(6'h01 << ($urandom % 6));
         wt(2, 1'b0, 10);
         // a command while the fault stands is spent; the host must repeat it
         fclr = !k[0];
         en = !k[0];
         repeat (8) @(negedge clk);
         chk("retry", 8'h00, {6'h0, ntf_n, sw.port_on});
         fclr = 1'b0;
         en = 1'b1;
         fault = '0;
         repeat (60) @(negedge clk);
         chk("latch", 8'h00, {6'h0, ntf_n, sw.port_on});
         fclr = !k[0];
         en = !k[0];
         wt(2, 1'b1, 20);
         fclr = 1'b0;
         en = 1'b1;
         wt(0, 1'b1, 100);
      end
      det_en = 1'b1;
      plug = 1'b0;
      wt(4, 1'b1, 20);
      chk("removal", 8'h5C, mon);
      wt(1, 1'b1, 30);
      sclr = 1'b1;
      wt(4, 1'b0, 10);
      sclr = 1'b0;
      give_verdict();
   end
endmodule
